// File: hw/pbu_ident_rom.sv
// Constant values of the type and identification registers.
// Assumes the selector comes from the bank's address decode.
`timescale 1ns/1ps
module pbu_ident_rom import pbu_pkg::*; #(
  parameter logic [11:0] PART_NUM = 12'h5a1, // Arbitrary value
  parameter logic [6:0] MAKER_CODE = 7'h2b, // Arbitrary value
  parameter logic [3:0] COMP_REV = 4'h1,
  parameter logic [3:0] REV_AND = 4'h0,
  parameter logic [3:0] CUST_MOD = 4'h0
)(
  input wire pbu_sel_t sel,
  output logic [31:0] value
);

  // Field packing per register, upper bits zero
  always_comb begin
    value = 32'h0000_0000;
    case (sel)
      PBU_SEL_TYPE: begin
        value[7:0] = {PBU_TYPE_SUB, PBU_TYPE_MAJOR}; // R1
      end
      PBU_SEL_ID0: begin
        value[7:0] = PART_NUM[7:0]; // R14
      end
      PBU_SEL_ID1: begin
        value[7:0] = {MAKER_CODE[3:0], PART_NUM[11:8]}; // R15
      end
      PBU_SEL_ID2: begin
        value[7:4] = COMP_REV; // R17
        value[PBU_ID2_STD_BIT] = PBU_ID2_STD_VAL; // R16
        value[2:0] = MAKER_CODE[6:4]; // R16
      end
      PBU_SEL_ID3: begin
        value[7:0] = {REV_AND, CUST_MOD};
      end
      default: begin
        value = 32'h0000_0000;
      end
    endcase
  end

endmodule // pbu_ident_rom

// File: hw/pbu_lock_regs.sv
// Software lock, lock status, component type and identification
// registers of the patch and breakpoint unit.
// Assumes one memory-mapped request per cycle with a one-cycle answer,
// and that the rest of the unit takes its writes from unit_wr_q.
//
// Functional notes
// R1 - Component type reads zero in subtype and major type, upper bits zero.
// R2 - Software full-word write of unlock key clears the lock.
// R3 - Any other value written to the key register sets the lock.
// R4 - Debugger sees key and status registers read zero, writes ignored.
// R5 - Without the lock built, key and status read zero, ignore writes.
// R6 - Key register is write-only, 32 bits, at its fixed address.
// R7 - Lock set drops software unit writes; reads have no side effects.
// R8 - Cold reset leaves the lock set.
// R9 - Lock set bit reads zero for debugger or when lock absent.
// R10 - Lock present bit reads one only for software with lock built.
// R11 - Width indicator bit of the status register always reads zero.
// R12 - Unprivileged accesses fault instead of completing.
// R13 - Accessors use word accesses only; smaller sizes are undefined.
// R14 - Ident 0 holds part number bits 7 to 0.
// R15 - Ident 1 holds part number 11 to 8 and maker code 3 to 0.
// R16 - Ident 2 bit 3 reads one; bits 2 to 0 hold maker code 6 to 4.
// R17 - Ident 2 bits 7 to 4 hold the component revision.
// R18 - One copy of every register, shared by both security states.
// R19 - Ident registers may be made debugger-only, zero for software.
// R20 - Status and ident registers read-only, 32 bits, at fixed addresses.
// R21 - One lock flop masks software unit writes; debugger writes bypass.
`timescale 1ns/1ps
module pbu_lock_regs import pbu_pkg::*; #(
  parameter bit LOCK_BUILT = 1'b1,
  parameter bit ID_DEBUG_ONLY = 1'b0,
  parameter logic [11:0] PART_NUM = 12'h5a1, // Arbitrary value
  parameter logic [6:0] MAKER_CODE = 7'h2b, // Arbitrary value
  parameter logic [3:0] COMP_REV = 4'h1,
  parameter logic [3:0] REV_AND = 4'h0,
  parameter logic [3:0] CUST_MOD = 4'h0
)(
  input wire logic mclk,
  input wire logic nrst,
  input wire pbu_req_t bus_req,
  output pbu_rsp_t bus_rsp_q,
  output pbu_fwd_t unit_wr_q,
  output logic lock_set_flag_q
);

  // Address lies inside the unit's 4 KB region
  function automatic logic in_region(input logic [31:0] a);
    in_region = (a & PBU_REGION_MASK) == PBU_REGION_BASE;
  endfunction

  // Map an address to the register it selects
  function automatic pbu_sel_t decode(input logic [31:0] a);
    case (a)
      PBU_ADDR_LOCK_KEY: decode = PBU_SEL_KEY;
      PBU_ADDR_LOCK_STATUS: decode = PBU_SEL_STATUS;
      PBU_ADDR_COMP_TYPE: decode = PBU_SEL_TYPE;
      PBU_ADDR_IDENT_0: decode = PBU_SEL_ID0;
      PBU_ADDR_IDENT_1: decode = PBU_SEL_ID1;
      PBU_ADDR_IDENT_2: decode = PBU_SEL_ID2;
      PBU_ADDR_IDENT_3: decode = PBU_SEL_ID3;
      default: decode = PBU_SEL_OTHER;
    endcase
  endfunction

  // Identification register selector
  function automatic logic is_ident(input pbu_sel_t s);
    is_ident = (s == PBU_SEL_ID0) || (s == PBU_SEL_ID1) ||
               (s == PBU_SEL_ID2) || (s == PBU_SEL_ID3);
  endfunction

  logic lock_q;
  logic lock_on;
  pbu_sel_t sel;
  logic hit;
  logic granted;
  logic sw_side;
  logic key_wr;
  logic fwd_ok;
  logic id_visible;
  logic [31:0] rom_value;
  logic [31:0] rdata_d;

  // Request qualification; size is not examined
  always_comb begin
    sel = decode(bus_req.addr); // R6 R20 R18
    hit = bus_req.valid && in_region(bus_req.addr);
    granted = hit && bus_req.priv; // R12 R13
    sw_side = !bus_req.dbg;
  end

  // Lock only counts when it is built
  assign lock_on = LOCK_BUILT && lock_q; // R5

  // Key write from software only
  assign key_wr = granted && bus_req.write && sel == PBU_SEL_KEY &&
                  sw_side && LOCK_BUILT; // R4 R5

  // Software writes pass only while unlocked
  assign fwd_ok = granted && bus_req.write && sel == PBU_SEL_OTHER &&
                  (bus_req.dbg || !lock_on); // R7 R21

  // Ident visibility for software
  assign id_visible = !(ID_DEBUG_ONLY && sw_side); // R19

  // Constant register contents
  pbu_ident_rom #(
    .PART_NUM(PART_NUM),
    .MAKER_CODE(MAKER_CODE),
    .COMP_REV(COMP_REV),
    .REV_AND(REV_AND),
    .CUST_MOD(CUST_MOD)
  ) u_rom (
    .sel(sel),
    .value(rom_value)
  );

  // Single lock flop, set at cold reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= PBU_LOCK_RESET; // R8
    end else if (key_wr) begin
      lock_q <= (bus_req.wdata != PBU_UNLOCK_KEY); // R2 R3
    end
  end

  // Read data selection
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (sel)
      PBU_SEL_STATUS: begin
        if (sw_side && LOCK_BUILT) begin // R4 R5 R9 R10
          rdata_d[PBU_LSR_PRESENT_BIT] = 1'b1; // R10
          rdata_d[PBU_LSR_SET_BIT] = lock_q; // R9
        end
        rdata_d[PBU_LSR_NARROW_BIT] = PBU_LSR_NARROW_VAL; // R11
      end
      PBU_SEL_TYPE: begin
        rdata_d = rom_value; // R1
      end
      PBU_SEL_ID0, PBU_SEL_ID1, PBU_SEL_ID2, PBU_SEL_ID3: begin
        if (id_visible) begin
          rdata_d = rom_value; // R14 R15 R16 R17
        end
      end
      PBU_SEL_KEY: begin
        rdata_d = 32'h0000_0000; // R6
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Answer, one cycle after the request
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_rsp_q <= '0;
    end else begin
      bus_rsp_q.valid <= hit;
      bus_rsp_q.fault <= hit && !bus_req.priv; // R12
      bus_rsp_q.rdata <= (granted && !bus_req.write) ? rdata_d : 32'h0000_0000;
    end
  end

  // Writes handed to the rest of the unit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      unit_wr_q <= '0;
    end else begin
      unit_wr_q.valid <= fwd_ok; // R7 R21
      unit_wr_q.addr <= fwd_ok ? bus_req.addr : 32'h0000_0000;
      unit_wr_q.wdata <= fwd_ok ? bus_req.wdata : 32'h0000_0000;
    end
  end

  // Lock state seen by the rest of the unit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lock_set_flag_q <= PBU_LOCK_RESET && LOCK_BUILT;
    end else begin
      lock_set_flag_q <= LOCK_BUILT && (key_wr ? (bus_req.wdata != PBU_UNLOCK_KEY) : lock_q);
    end
  end

  // Helper: request qualifiers for the checks
  logic sw_key_ok;
  logic sw_key_bad;
  logic dbg_key_wr;
  logic sw_status_rd;
  logic dbg_status_rd;
  logic unpriv_req;
  logic locked_sw_wr;
  logic sw_id_rd;

  always_comb begin
    sw_key_ok = key_wr && bus_req.wdata == PBU_UNLOCK_KEY;
    sw_key_bad = key_wr && bus_req.wdata != PBU_UNLOCK_KEY;
    dbg_key_wr = granted && bus_req.write && sel == PBU_SEL_KEY && bus_req.dbg;
    sw_status_rd = granted && !bus_req.write && sel == PBU_SEL_STATUS && sw_side;
    dbg_status_rd = granted && !bus_req.write && sel == PBU_SEL_STATUS && bus_req.dbg;
    unpriv_req = hit && !bus_req.priv;
    locked_sw_wr = granted && bus_req.write && sw_side && lock_on;
    sw_id_rd = granted && !bus_req.write && is_ident(sel) && sw_side;
  end

  // Lock is set while held in reset and on the first edge after
  property p_lock_reset;
    @(posedge mclk) $rose(nrst) |-> lock_q && (lock_set_flag_q == LOCK_BUILT);
  endproperty
  a_lock_reset: assert property (p_lock_reset) // R8
    else $error("lock not set after reset");

  // Correct key clears the lock, visible on lock_set_flag_q
  property p_unlock;
    @(posedge mclk) disable iff (!nrst)
    sw_key_ok |=> !lock_q && !lock_set_flag_q;
  endproperty
  a_unlock: assert property (p_unlock) // R2
    else $error("unlock key did not clear lock");

  // Any other key sets the lock
  property p_relock;
    @(posedge mclk) disable iff (!nrst)
    sw_key_bad |=> lock_q && lock_set_flag_q;
  endproperty
  a_relock: assert property (p_relock) // R3
    else $error("wrong key did not set lock");

  // Debugger key write reads zero and leaves the lock alone
  property p_dbg_key;
    @(posedge mclk) disable iff (!nrst)
    dbg_key_wr && !key_wr |=> $stable(lock_q) && bus_rsp_q.rdata == 32'h0000_0000;
  endproperty
  a_dbg_key: assert property (p_dbg_key) // R4
    else $error("debugger key write took effect");

  // Software status read shows the lock and presence
  property p_sw_status;
    logic was_locked;
    @(posedge mclk) disable iff (!nrst)
    (sw_status_rd, was_locked = lock_q) |=>
      bus_rsp_q.valid && bus_rsp_q.rdata ==
      (LOCK_BUILT ? {29'h0, 1'b0, was_locked, 1'b1} : 32'h0000_0000);
  endproperty
  a_sw_status: assert property (p_sw_status) // R10
    else $error("software status read wrong");

  // Debugger status read is all zero, width bit included
  property p_dbg_status;
    @(posedge mclk) disable iff (!nrst)
    dbg_status_rd |=> bus_rsp_q.rdata == 32'h0000_0000 && !bus_rsp_q.fault;
  endproperty
  a_dbg_status: assert property (p_dbg_status) // R9
    else $error("debugger status read not zero");

  // Unprivileged access faults with no data and no forwarded write
  property p_unpriv;
    @(posedge mclk) disable iff (!nrst)
    unpriv_req |=> bus_rsp_q.valid && bus_rsp_q.fault &&
      bus_rsp_q.rdata == 32'h0000_0000 && !unit_wr_q.valid;
  endproperty
  a_unpriv: assert property (p_unpriv) // R12
    else $error("unprivileged access not faulted");

  // Locked software writes never reach the unit
  property p_locked_drop;
    @(posedge mclk) disable iff (!nrst)
    locked_sw_wr |=> !unit_wr_q.valid;
  endproperty
  a_locked_drop: assert property (p_locked_drop) // R7
    else $error("locked software write forwarded");

  // Forwarded write means debugger or unlocked software one cycle earlier
  property p_fwd_cause;
    @(posedge mclk) disable iff (!nrst)
    unit_wr_q.valid |-> $past(bus_req.dbg) || !$past(lock_on);
  endproperty
  a_fwd_cause: assert property (p_fwd_cause) // R21
    else $error("forwarded write without permission");

  // Component type reads zero
  property p_type_zero;
    @(posedge mclk) disable iff (!nrst)
    granted && !bus_req.write && sel == PBU_SEL_TYPE |=> bus_rsp_q.rdata == 32'h0000_0000;
  endproperty
  a_type_zero: assert property (p_type_zero) // R1
    else $error("component type not zero");

  // Ident 2 standard bit reads one when visible
  property p_id2_std;
    @(posedge mclk) disable iff (!nrst)
    granted && !bus_req.write && sel == PBU_SEL_ID2 && id_visible |=>
      bus_rsp_q.rdata[PBU_ID2_STD_BIT] && bus_rsp_q.rdata[31:8] == 24'h000000;
  endproperty
  a_id2_std: assert property (p_id2_std) // R16
    else $error("ident 2 standard bit wrong");

  // Hidden ident reads zero for software
  property p_id_hidden;
    @(posedge mclk) disable iff (!nrst)
    sw_id_rd && ID_DEBUG_ONLY |=> bus_rsp_q.rdata == 32'h0000_0000;
  endproperty
  a_id_hidden: assert property (p_id_hidden) // R19
    else $error("hidden ident visible to software");

  // Debugger writes to unit registers pass even while locked
  property p_dbg_pass;
    @(posedge mclk) disable iff (!nrst)
    granted && bus_req.write && bus_req.dbg && sel == PBU_SEL_OTHER |=> unit_wr_q.valid;
  endproperty
  a_dbg_pass: assert property (p_dbg_pass) // R21
    else $error("debugger write was dropped");

  // Software writes are accepted while the lock is clear
  property p_sw_pass;
    @(posedge mclk) disable iff (!nrst)
    granted && bus_req.write && sw_side && !lock_q && sel == PBU_SEL_OTHER |=> unit_wr_q.valid;
  endproperty
  a_sw_pass: assert property (p_sw_pass) // R7
    else $error("unlocked software write was dropped");

  // Status read keeps the width bit and all upper bits at zero
  property p_narrow_zero;
    @(posedge mclk) disable iff (!nrst)
    granted && !bus_req.write && sel == PBU_SEL_STATUS |=>
      !bus_rsp_q.rdata[PBU_LSR_NARROW_BIT] && bus_rsp_q.rdata[31:3] == 29'h0;
  endproperty
  a_narrow_zero: assert property (p_narrow_zero) // R11
    else $error("status width or upper bits not zero");

  // Key register is write-only and reads zero
  property p_key_read_zero;
    @(posedge mclk) disable iff (!nrst)
    granted && !bus_req.write && sel == PBU_SEL_KEY |=> bus_rsp_q.valid && bus_rsp_q.rdata == 32'h0000_0000;
  endproperty
  a_key_read_zero: assert property (p_key_read_zero) // R6
    else $error("key register read not zero");

  // Unlock then a forwarded software write
  c_unlock_write: cover property (@(posedge mclk) disable iff (!nrst)
    sw_key_ok ##1 (granted && bus_req.write && sw_side && sel == PBU_SEL_OTHER)
    ##1 unit_wr_q.valid);

  // Unlock followed by relock
  c_relock: cover property (@(posedge mclk) disable iff (!nrst)
    sw_key_ok ##[1:8] sw_key_bad);

  // Unprivileged fault answer
  c_fault: cover property (@(posedge mclk) disable iff (!nrst)
    unpriv_req ##1 bus_rsp_q.fault);

  // Debugger write passes while locked
  c_dbg_bypass: cover property (@(posedge mclk) disable iff (!nrst)
    lock_on && bus_req.dbg && granted && bus_req.write && sel == PBU_SEL_OTHER
    ##1 unit_wr_q.valid);

endmodule // pbu_lock_regs

// File: hw/pbu_pkg.sv
// Package for the patch unit lock and identification register bank.
// Assumes a single 200 MHz clock and a word-wide memory-mapped request.
package pbu_pkg;

  // Clock period in ns, kept for timing math
  localparam int PBU_CLK_PERIOD_NS = 5;

  // Unit region and register addresses
  localparam logic [31:0] PBU_REGION_BASE = 32'he0002000;
  localparam logic [31:0] PBU_REGION_MASK = 32'hfffff000;
  localparam logic [31:0] PBU_ADDR_LOCK_KEY = 32'he0002fb0;
  localparam logic [31:0] PBU_ADDR_LOCK_STATUS = 32'he0002fb4;
  localparam logic [31:0] PBU_ADDR_COMP_TYPE = 32'he0002fcc;
  localparam logic [31:0] PBU_ADDR_IDENT_0 = 32'he0002fe0;
  localparam logic [31:0] PBU_ADDR_IDENT_1 = 32'he0002fe4;
  localparam logic [31:0] PBU_ADDR_IDENT_2 = 32'he0002fe8;
  localparam logic [31:0] PBU_ADDR_IDENT_3 = 32'he0002fec;

  // Unlock key value
  localparam logic [31:0] PBU_UNLOCK_KEY = 32'hc5acce55;

  // Lock status field positions
  localparam int PBU_LSR_PRESENT_BIT = 0;
  localparam int PBU_LSR_SET_BIT = 1;
  localparam int PBU_LSR_NARROW_BIT = 2;
  localparam logic PBU_LSR_NARROW_VAL = 1'b0;

  // Lock reset value, set after cold reset
  localparam logic PBU_LOCK_RESET = 1'b1;

  // Component type fields, both read zero
  localparam logic [3:0] PBU_TYPE_SUB = 4'h0;
  localparam logic [3:0] PBU_TYPE_MAJOR = 4'h0;

  // Identification field positions
  localparam int PBU_ID2_STD_BIT = 3;
  localparam logic PBU_ID2_STD_VAL = 1'b1;

  // Access sizes on the bus
  typedef enum logic [1:0] {
    PBU_SZ_BYTE = 2'b00,
    PBU_SZ_HALF = 2'b01,
    PBU_SZ_WORD = 2'b10
  } pbu_size_t;

  // Register selected by an address
  typedef enum logic [2:0] {
    PBU_SEL_OTHER = 3'b000,
    PBU_SEL_KEY = 3'b001,
    PBU_SEL_STATUS = 3'b010,
    PBU_SEL_TYPE = 3'b011,
    PBU_SEL_ID0 = 3'b100,
    PBU_SEL_ID1 = 3'b101,
    PBU_SEL_ID2 = 3'b110,
    PBU_SEL_ID3 = 3'b111
  } pbu_sel_t;

  // Memory-mapped request
  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic dbg;
    pbu_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pbu_req_t;

  // Answer to a request
  typedef struct packed {
    logic valid;
    logic fault;
    logic [31:0] rdata;
  } pbu_rsp_t;

  // Write passed on to the rest of the unit
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pbu_fwd_t;

endpackage

// File: verification/pbu_bus_master.sv
// Bus master model standing for the core and the debugger.
// Assumes the bench calls send and idle in sequence, one request per cycle.
`timescale 1ns/1ps
module pbu_bus_master import pbu_pkg::*; (
  input wire logic mclk,
  output pbu_req_t req
);
  initial req = '0;

  // Launch one request just after a rising edge, held for one cycle
  task automatic send(input pbu_req_t r);
    @(posedge mclk);
    r.valid = 1'b1;
    r.size = PBU_SZ_WORD;
    req <= r;
  endtask

  // Released bus: fields wander so a stale value is never mistaken for a request
  task automatic idle();
    @(posedge mclk);
    req <= '{valid: 1'b0, write: 1'($urandom), priv: 1'($urandom), dbg: 1'($urandom),
      size: PBU_SZ_WORD, addr: $urandom, wdata: $urandom};
  endtask
endmodule // pbu_bus_master

// File: verification/test_pbu_lock_regs.sv
// Self-checking bench for the lock and identification register bank.
// Assumes the bus master model drives requests; a monitor compares answers.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_pbu_lock_regs import pbu_pkg::*;;
  localparam logic [11:0] PART = 12'h3c7; // Arbitrary value
  localparam logic [6:0] MAKER = 7'h15; // Arbitrary value
  localparam logic [3:0] REV = 4'h2;
  localparam logic [3:0] RAND = 4'h3;
  localparam logic [3:0] CMOD = 4'h4;
  typedef struct packed {pbu_rsp_t r; pbu_fwd_t f; logic lk;} pbu_exp_t;
  logic mclk;
  logic nrst;
  pbu_req_t bus_req;
  pbu_rsp_t rsp[2];
  pbu_fwd_t fwd[2];
  logic lk[2];
  logic lock_q[2];
  pbu_exp_t q0[$];
  pbu_exp_t q1[$];
  pbu_exp_t e0;
  pbu_exp_t e1;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] adr[9] = '{PBU_ADDR_LOCK_KEY, PBU_ADDR_LOCK_STATUS, PBU_ADDR_COMP_TYPE, PBU_ADDR_IDENT_0,
    PBU_ADDR_IDENT_1, PBU_ADDR_IDENT_2, PBU_ADDR_IDENT_3, 32'he0002008, 32'he0003008};

  pbu_bus_master pbu_bus_master_inst (.mclk(mclk), .req(bus_req));
  pbu_lock_regs #(.PART_NUM(PART), .MAKER_CODE(MAKER), .COMP_REV(REV), .REV_AND(RAND), .CUST_MOD(CMOD))
    pbu_lock_regs_inst (.mclk(mclk), .nrst(nrst), .bus_req(bus_req), .bus_rsp_q(rsp[0]), .unit_wr_q(fwd[0]),
    .lock_set_flag_q(lk[0]));
  pbu_lock_regs #(.LOCK_BUILT(1'b0), .ID_DEBUG_ONLY(1'b1), .PART_NUM(PART), .MAKER_CODE(MAKER),
    .COMP_REV(REV), .REV_AND(RAND), .CUST_MOD(CMOD))
    pbu_lock_regs_nolock_inst (.mclk(mclk), .nrst(nrst), .bus_req(bus_req), .bus_rsp_q(rsp[1]),
    .unit_wr_q(fwd[1]), .lock_set_flag_q(lk[1]));

  // Clock at 200 MHz
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Expected answer of one bank build to one request
  function automatic pbu_exp_t ref_of(pbu_req_t r, bit built, bit idonly, inout logic lock);
    pbu_exp_t e = '0;
    logic sw = built && !r.dbg;
    logic ro = r.addr == PBU_ADDR_LOCK_STATUS || r.addr == PBU_ADDR_COMP_TYPE || r.addr[11:4] == 8'hfe;
    e.r.valid = 1'b1;
    if (!r.priv) begin
      e.r.fault = 1'b1;
    end else if (r.write) begin
      if (r.addr == PBU_ADDR_LOCK_KEY) begin
        if (sw) lock = r.wdata != PBU_UNLOCK_KEY;
      end else if (!ro && (r.dbg || !(built && lock))) begin
        e.f = '{1'b1, r.addr, r.wdata};
      end
    end else if (!(idonly && !r.dbg) || r.addr[11:4] != 8'hfe) begin
      case (r.addr)
        PBU_ADDR_LOCK_STATUS: e.r.rdata = {29'h0, 1'b0, lock & sw, sw};
        PBU_ADDR_IDENT_0: e.r.rdata = {24'h0, PART[7:0]};
        PBU_ADDR_IDENT_1: e.r.rdata = {24'h0, MAKER[3:0], PART[11:8]};
        PBU_ADDR_IDENT_2: e.r.rdata = {24'h0, REV, 1'b1, MAKER[6:4]};
        PBU_ADDR_IDENT_3: e.r.rdata = {24'h0, RAND, CMOD};
        default: e.r.rdata = '0;
      endcase
    end
    e.lk = built && lock;
    return e;
  endfunction

  // Note the expectation for both builds of an in-region request, then send the request
  task automatic acc(logic w, logic p, logic d, int i, logic [31:0] wd);
    pbu_req_t r;
    r = '{1'b1, w, p, d, PBU_SZ_WORD, adr[i], wd};
    if (i < 8) begin
      q0.push_back(ref_of(r, 1'b1, 1'b0, lock_q[0]));
      q1.push_back(ref_of(r, 1'b0, 1'b1, lock_q[1]));
    end
    pbu_bus_master_inst.send(r);
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    lock_q = '{1'b1, 1'b1};
    @(negedge mclk);
    `CHK(lk[0], 1'b1)
  endtask

  task automatic end_test(string s);
    pbu_bus_master_inst.idle();
    repeat (3) @(posedge mclk);
    $display("Test %s done", s);
  endtask

  task automatic finish_test();
    `CHK(q0.size() + q1.size(), 0)
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Monitor: each answer takes the oldest note off the queues
  always @(negedge mclk) begin
    if (rsp[0].valid !== 1'b0 || rsp[1].valid !== 1'b0) begin
      e0 = q0.size() > 0 ? q0.pop_front() : '1;
      e1 = q1.size() > 0 ? q1.pop_front() : '1;
      `CHK(rsp[0].valid, e0.r.valid)
      `CHK(rsp[0].fault, e0.r.fault)
      `CHK(rsp[0].rdata, e0.r.rdata)
      `CHK(fwd[0], e0.f)
      `CHK(lk[0], e0.lk)
      `CHK(rsp[1], e1.r)
      `CHK({fwd[1], lk[1]}, {e1.f, e1.lk})
    end else begin
      `CHK(fwd[0].valid, 1'b0)
    end
  end

  // Watchdog, far beyond the roughly 170 cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end

  initial begin
    nrst = 1'b0;
    void'($urandom(32'h6f3f));
    do_reset();
    // Locked after reset: software writes dropped, debugger passes
    acc(0, 1, 0, 1, 0); acc(0, 1, 1, 1, 0); acc(1, 1, 0, 7, 32'h12345679); acc(1, 1, 1, 7, 32'h0badf00d);
    acc(1, 1, 1, 0, PBU_UNLOCK_KEY); acc(1, 1, 0, 7, 32'h5); acc(0, 1, 1, 0, 0);
    end_test("locked");
    acc(1, 1, 0, 0, PBU_UNLOCK_KEY); acc(1, 1, 0, 7, 32'ha5a5a5a5); acc(0, 1, 0, 1, 0); acc(0, 1, 0, 0, 0);
    end_test("unlock");
    acc(1, 1, 0, 0, PBU_UNLOCK_KEY ^ 32'h1); acc(1, 1, 0, 7, 32'h77); acc(0, 1, 0, 1, 0);
    acc(1, 1, 0, 0, PBU_UNLOCK_KEY); acc(1, 1, 1, 0, 32'h5); acc(0, 1, 0, 1, 0);
    end_test("relock");
    for (int i = 1; i < 7; i++) begin
      acc(1, 1, 0, i, 32'hffffffff); acc(0, 1, 0, i, 0); acc(0, 1, 1, i, 0);
    end
    end_test("ident");
    for (int i = 0; i < 9; i++) begin
      acc(1, 0, 0, i, 0); acc(0, 0, 1, i, 0);
    end
    acc(1, 1, 0, 7, 32'h9); acc(1, 1, 0, 8, 32'h9);
    end_test("fault");
    repeat (80) begin
      int i;
      i = $urandom % 9;
      acc(i == 7 || 1'($urandom), $urandom % 4 != 0, 1'($urandom), i, 1'($urandom) ? PBU_UNLOCK_KEY : $urandom);
    end
    end_test("random");
    do_reset();
    acc(0, 1, 0, 1, 0); acc(1, 1, 0, 7, 32'h3);
    end_test("reset");
    finish_test();
  end
endmodule // test_pbu_lock_regs
